// File: rtl/pwl_pkg.sv
`default_nettype none
package pwl_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_FLAG = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [7:0] ADDR_VOLT = 8'h10;
  localparam logic [7:0] ADDR_BAND = 8'h14;
  // Control fields
  localparam int CTRL_PIN1_USER = 0;
  localparam int CTRL_OUT2_USER = 1;
  localparam int CTRL_PIN3_USER = 2;
  localparam int CTRL_MEMSEL = 3;
  localparam int CTRL_PUSHPULL = 4;
  localparam int CTRL_CONVRST = 5;
  localparam int CTRL_TRST = 6;
  localparam logic [6:0] CTRL_RST = 7'h03;
  // Flag and mask bits
  localparam int IRQ_BUTTON = 0;
  localparam int IRQ_CHARGER = 1;
  localparam int IRQ_FAULT = 2;
  localparam int IRQ_W = 3;
  localparam logic [2:0] MASK_RST = 3'h0;
  // Status fields
  localparam int STAT_BUTTON = 0;
  localparam int STAT_CHARGER = 1;
  localparam int STAT_ACTIVE = 2;
  localparam int STAT_RESTART = 3;
  // Voltage codes
  localparam logic [5:0] BUCK_ONE_DEF = 6'h0f;
  localparam logic [5:0] BUCK_TWO_DEF = 6'h0f;
  localparam logic [5:0] BUCK_THREE_DEF = 6'h13;
  localparam logic [5:0] BB_FOUR_DEF = 6'h3d;
  localparam logic [5:0] B3_BAND1 = 6'h12;
  localparam logic [5:0] B3_BAND2 = 6'h18;
  localparam logic [5:0] B3_BAND3 = 6'h1f;
  localparam logic [5:0] B3_BAND4 = 6'h3d;
  localparam logic [5:0] B4_BAND4 = 6'h01;
  localparam logic [5:0] B4_BAND5 = 6'h07;
  localparam logic [5:0] B4_BAND6 = 6'h0d;
  localparam logic [5:0] B4_BAND7 = 6'h14;
  // Slew: any nonzero value starts the walk; codes move one step per slow tick
  localparam logic [3:0] SLEW_TICKS = 4'h1;
  // Timing, in slow 32 kHz ticks, except the fault bound in pclk cycles
  localparam int SLOW_HZ = 32768;
  localparam int CLK_HZ = 50000000;
  localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;
  localparam int POWERUP_MS = 600;
  localparam int SHORT_S = 8;
  localparam int LONG_S = 15;
  localparam int PWRDN_MS = 500;
  localparam int WAKE_TICKS = 5;
  localparam int POWERUP_TICKS = (POWERUP_MS * SLOW_HZ + 999) / 1000;
  localparam int SHORT_TICKS = SHORT_S * SLOW_HZ;
  localparam int LONG_TICKS = LONG_S * SLOW_HZ;
  localparam int PWRDN_TICKS = (PWRDN_MS * SLOW_HZ + 999) / 1000;
  localparam int FAULT_US = 32;
  localparam int FAULT_CYCLES = FAULT_US * (CLK_HZ / 1000000);
endpackage
`default_nettype wire

// File: rtl/pwl_edge_sync.sv
`default_nettype none
// Two-stage synchroniser with a third stage for edge detection
module pwl_edge_sync
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic sample,
  input wire logic async_in,
  input wire logic init_val,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic last_q;
  logic primed_q;
  logic [1:0] fill_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      fill_q <= 2'h0;
    end
    else if (en)
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
      if (fill_q != 2'h2)
        fill_q <= fill_q + 2'h1;
    end
  end

  // Edge stage moves on the sample strobe, and only once the pin level
  // has reached sync_q: the chain's reset value is never seen as an edge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      last_q <= 1'b1;
      primed_q <= 1'b0;
    end
    else if (en && sample && fill_q == 2'h2)
    begin
      last_q <= sync_q;
      primed_q <= 1'b1;
    end
  end

  assign level = primed_q ? last_q : init_val;
  assign rise = en && sample && primed_q && !last_q && sync_q;
  assign fall = en && sample && primed_q && last_q && !sync_q;
endmodule
`default_nettype wire

// File: rtl/pwl_core.sv
`default_nettype none
module pwl_core
#(
  parameter int SHORT_TICKS = pwl_pkg::SHORT_TICKS,
  parameter int LONG_TICKS = pwl_pkg::LONG_TICKS,
  parameter int POWERUP_TICKS = pwl_pkg::POWERUP_TICKS,
  parameter int PWRDN_TICKS = pwl_pkg::PWRDN_TICKS,
  parameter int SLOW_DIV = pwl_pkg::SLOW_DIV
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] sel_band,
  input wire logic power_good,
  input wire logic fault_in,
  input wire logic push_button_in,
  input wire logic charger_detect_in,
  input wire logic io_pin_one_i,
  output logic io_pin_one_o,
  output logic io_pin_one_oe,
  output logic mem_reset_out_pin_o,
  output logic mem_reset_out_pin_oe,
  input wire logic io_pin_three_i,
  output logic io_pin_three_o,
  output logic io_pin_three_oe,
  output logic wake_out_n_o,
  output logic wake_out_n_oe,
  output logic irq_out_o,
  output logic irq_out_oe,
  output logic rails_on,
  output logic [5:0] buck_one,
  output logic [5:0] buck_two,
  output logic [5:0] buck_three,
  output logic [5:0] buckboost_four
);
  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [5:0] step_to(input logic [5:0] cur,
                                         input logic [5:0] tgt);
    if (cur < tgt)
      step_to = cur + 6'h01;
    else if (cur > tgt)
      step_to = cur - 6'h01;
    else
      step_to = cur;
  endfunction

  function automatic logic [5:0] band3(input logic [2:0] b);
    unique case (b)
      3'h1: band3 = pwl_pkg::B3_BAND1;
      3'h2: band3 = pwl_pkg::B3_BAND2;
      3'h3: band3 = pwl_pkg::B3_BAND3;
      3'h4: band3 = pwl_pkg::B3_BAND4;
      default: band3 = pwl_pkg::BUCK_THREE_DEF;
    endcase
  endfunction

  function automatic logic [5:0] band4(input logic [2:0] b);
    unique case (b)
      3'h4: band4 = pwl_pkg::B4_BAND4;
      3'h5: band4 = pwl_pkg::B4_BAND5;
      3'h6: band4 = pwl_pkg::B4_BAND6;
      3'h7: band4 = pwl_pkg::B4_BAND7;
      default: band4 = pwl_pkg::BB_FOUR_DEF;
    endcase
  endfunction

  // ****************************************
  // Slow tick and synchronisers
  // ****************************************
  typedef enum {ST_OFF, ST_ACTIVE, ST_PWRDN, ST_RESTART} pwl_state_e;
  pwl_state_e state_q;
  logic [11:0] div_q;
  logic [19:0] tmr_q;
  logic [19:0] press_q;
  logic [2:0] wake_q;
  logic [3:0] slew_q;
  logic tick;
  assign tick = clk_en && (div_q == 12'(SLOW_DIV - 1));

  logic btn_lvl, btn_rise, btn_fall;
  logic chg_lvl, chg_rise, chg_fall;
  logic p3_fall;
  logic pg_lvl, pg_fall_u, pg_rise_u;
  logic p1_lvl, p1_rise_u, p1_fall_u;
  logic flt_lvl, flt_rise_u, flt_fall_u;

  pwl_edge_sync u_btn (.clk(pclk), .rst_n(presetn), .en(clk_en),
    .sample(tick), .async_in(push_button_in), .init_val(1'b1),
    .level(btn_lvl), .rise(btn_rise), .fall(btn_fall));
  pwl_edge_sync u_chg (.clk(pclk), .rst_n(presetn), .en(clk_en),
    .sample(tick), .async_in(charger_detect_in), .init_val(1'b1),
    .level(chg_lvl), .rise(chg_rise), .fall(chg_fall));
  pwl_edge_sync u_p3 (.clk(pclk), .rst_n(presetn), .en(clk_en),
    .sample(1'b1), .async_in(io_pin_three_i), .init_val(1'b1),
    .level(), .rise(), .fall(p3_fall));
  pwl_edge_sync u_pg (.clk(pclk), .rst_n(presetn), .en(clk_en),
    .sample(1'b1), .async_in(power_good), .init_val(1'b0),
    .level(pg_lvl), .rise(pg_rise_u), .fall(pg_fall_u));
  pwl_edge_sync u_p1 (.clk(pclk), .rst_n(presetn), .en(clk_en),
    .sample(1'b1), .async_in(io_pin_one_i), .init_val(1'b0),
    .level(p1_lvl), .rise(p1_rise_u), .fall(p1_fall_u));
  pwl_edge_sync u_flt (.clk(pclk), .rst_n(presetn), .en(clk_en),
    .sample(1'b1), .async_in(fault_in), .init_val(1'b0),
    .level(flt_lvl), .rise(flt_rise_u), .fall(flt_fall_u));

  // ****************************************
  // Registers and APB decode
  // ****************************************
  logic [6:0] ctrl_q;
  logic [2:0] mask_q;
  logic [2:0] flag_q;
  logic [2:0] flag_d;
  logic [9:0] fault_cnt_q;
  logic active;
  logic wr_ctrl, wr_mask, rd_flag, acc, mapped;
  logic [31:0] rdata_d;
  logic [2:0] events;

  assign active = (state_q == ST_ACTIVE);
  assign acc = clk_en && psel && penable && !pready;
  assign mapped = (paddr == pwl_pkg::ADDR_CTRL) ||
                  (paddr == pwl_pkg::ADDR_MASK) ||
                  (paddr == pwl_pkg::ADDR_FLAG) ||
                  (paddr == pwl_pkg::ADDR_STAT) ||
                  (paddr == pwl_pkg::ADDR_VOLT) ||
                  (paddr == pwl_pkg::ADDR_BAND);
  assign wr_ctrl = acc && pwrite && (paddr == pwl_pkg::ADDR_CTRL);
  assign wr_mask = acc && pwrite && (paddr == pwl_pkg::ADDR_MASK);
  assign rd_flag = acc && !pwrite && (paddr == pwl_pkg::ADDR_FLAG);

  // Fault rechecked periodically, well inside the 32 us bound
  logic fault_poll;
  assign fault_poll = clk_en && flt_lvl &&
                      (fault_cnt_q == 10'(pwl_pkg::FAULT_CYCLES / 2));

  assign events[pwl_pkg::IRQ_BUTTON] = active && (btn_rise || btn_fall);
  assign events[pwl_pkg::IRQ_CHARGER] = active && (chg_rise || chg_fall);
  assign events[pwl_pkg::IRQ_FAULT] = fault_poll;
  // Set beats the read clear; masks play no part here
  assign flag_d = (rd_flag ? 3'h0 : flag_q) | events;

  always_comb
  begin
    unique case (paddr)
      pwl_pkg::ADDR_CTRL: rdata_d = {25'h0, ctrl_q};
      pwl_pkg::ADDR_MASK: rdata_d = {29'h0, mask_q};
      pwl_pkg::ADDR_FLAG: rdata_d = {29'h0, flag_q};
      pwl_pkg::ADDR_STAT: rdata_d = {28'h0, state_q == ST_RESTART, active,
                                     chg_lvl, btn_lvl};
      pwl_pkg::ADDR_VOLT: rdata_d = {8'h0, buckboost_four, buck_three,
                                     buck_two, buck_one};
      pwl_pkg::ADDR_BAND: rdata_d = {29'h0, sel_band};
      default: rdata_d = 32'h0;
    endcase
  end

  // One wait state: answer one cycle after the access phase starts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else if (clk_en)
    begin
      pready <= acc;
      pslverr <= acc && !mapped;
      prdata <= (acc && !pwrite) ? rdata_d : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= pwl_pkg::CTRL_RST;
      mask_q <= pwl_pkg::MASK_RST;
      flag_q <= 3'h0;
      fault_cnt_q <= 10'h000;
    end
    else if (clk_en)
    begin
      if (wr_ctrl)
        ctrl_q <= pwdata[6:0];
      if (wr_mask)
        mask_q <= pwdata[2:0];
      flag_q <= flag_d;
      fault_cnt_q <= (fault_cnt_q == 10'(pwl_pkg::FAULT_CYCLES / 2)) ?
                     10'h000 : fault_cnt_q + 10'h001;
    end
  end

  // ****************************************
  // Power state and button timing
  // ****************************************
  logic [19:0] press_lim;
  logic long_press, wake_req;
  assign press_lim = ctrl_q[pwl_pkg::CTRL_TRST] ?
                     20'(LONG_TICKS) : 20'(SHORT_TICKS);
  assign long_press = tick && !btn_lvl && (press_q >= press_lim - 20'h1);
  assign wake_req = chg_fall;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_q <= 12'h0;
      press_q <= 20'h0;
      tmr_q <= 20'h0;
      state_q <= ST_OFF;
    end
    else if (clk_en)
    begin
      div_q <= (div_q == 12'(SLOW_DIV - 1)) ? 12'h0 : div_q + 12'h001;
      if (tick)
        press_q <= (btn_lvl || long_press) ? 20'h0 : press_q + 20'h1;
      unique case (state_q)
        ST_OFF:
          if ((tick && !btn_lvl && press_q >= 20'(POWERUP_TICKS - 1)) ||
              wake_req)
          begin
            state_q <= ST_ACTIVE;
          end
        ST_ACTIVE:
          if (long_press)
          begin
            state_q <= ST_PWRDN;
            tmr_q <= 20'h0;
          end
        ST_PWRDN:
          if (tick)
          begin
            tmr_q <= tmr_q + 20'h1;
            if (tmr_q == 20'(PWRDN_TICKS - 1))
              state_q <= ST_RESTART;
          end
        ST_RESTART:
          state_q <= ST_ACTIVE;
      endcase
    end
  end

  // ****************************************
  // Pin logic and converter codes
  // ****************************************
  logic mem_latch_q;
  logic mem_level, out2_level, pushpull, conv_rst, seeded_q;
  assign pushpull = ctrl_q[pwl_pkg::CTRL_PUSHPULL];
  assign conv_rst = ctrl_q[pwl_pkg::CTRL_CONVRST] && p3_fall;
  assign mem_level = pg_lvl ? p1_lvl : mem_latch_q;
  assign out2_level = ctrl_q[pwl_pkg::CTRL_MEMSEL] ? mem_level :
                      ctrl_q[pwl_pkg::CTRL_OUT2_USER];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_latch_q <= 1'b0;
      wake_q <= 3'h0;
      seeded_q <= 1'b0;
      slew_q <= 4'h0;
      buck_one <= pwl_pkg::BUCK_ONE_DEF;
      buck_two <= pwl_pkg::BUCK_TWO_DEF;
      buck_three <= pwl_pkg::BUCK_THREE_DEF;
      buckboost_four <= pwl_pkg::BB_FOUR_DEF;
      io_pin_one_o <= 1'b0;
      io_pin_one_oe <= 1'b0;
      mem_reset_out_pin_o <= 1'b0;
      mem_reset_out_pin_oe <= 1'b1;
      io_pin_three_o <= 1'b0;
      io_pin_three_oe <= 1'b0;
      wake_out_n_o <= 1'b0;
      wake_out_n_oe <= 1'b0;
      irq_out_o <= 1'b0;
      irq_out_oe <= 1'b0;
      rails_on <= 1'b0;
    end
    else if (clk_en)
    begin
      if (pg_fall_u)
        mem_latch_q <= p1_lvl;
      // Band seen once, after reset release
      if (!seeded_q)
      begin
        seeded_q <= 1'b1;
        buck_three <= band3(sel_band);
        buckboost_four <= band4(sel_band);
      end
      // Rails stay up; buck_one and buck_two only walk back toward default
      if (conv_rst)
        slew_q <= pwl_pkg::SLEW_TICKS;
      else if (tick && slew_q != 4'h0)
      begin
        buck_one <= step_to(buck_one, pwl_pkg::BUCK_ONE_DEF);
        buck_two <= step_to(buck_two, pwl_pkg::BUCK_TWO_DEF);
        if (buck_one == pwl_pkg::BUCK_ONE_DEF &&
            buck_two == pwl_pkg::BUCK_TWO_DEF)
          slew_q <= 4'h0;
      end
      if (active && btn_fall)
        wake_q <= 3'(pwl_pkg::WAKE_TICKS);
      else if (tick && wake_q != 3'h0)
        wake_q <= wake_q - 3'h1;
      io_pin_one_o <= 1'b0;
      io_pin_one_oe <= !ctrl_q[pwl_pkg::CTRL_MEMSEL] &&
                       !ctrl_q[pwl_pkg::CTRL_PIN1_USER];
      mem_reset_out_pin_o <= out2_level;
      mem_reset_out_pin_oe <= pushpull || !out2_level;
      io_pin_three_o <= 1'b0;
      io_pin_three_oe <= !ctrl_q[pwl_pkg::CTRL_CONVRST] &&
                         !ctrl_q[pwl_pkg::CTRL_PIN3_USER];
      wake_out_n_o <= 1'b0;
      wake_out_n_oe <= (wake_q != 3'h0);
      irq_out_o <= 1'b0;
      irq_out_oe <= |(flag_d & ~mask_q);
      rails_on <= (state_q == ST_ACTIVE);
    end
  end
endmodule
`default_nettype wire

// File: test/pwl_core_sva.sv
`default_nettype none
// ****
// Port checker
// ****
module pwl_core_sva
#(
  parameter int SLOW_DIV = 4
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic io_pin_one_oe,
  input wire logic mem_reset_out_pin_o,
  input wire logic mem_reset_out_pin_oe,
  input wire logic io_pin_three_oe,
  input wire logic wake_out_n_oe,
  input wire logic irq_out_oe,
  input wire logic [5:0] buck_one,
  input wire logic [5:0] buck_two
);
  logic [6:0] ctrl_q;
  logic [1:0] settle_q;
  logic [1:0] clr_q;
  int wake_q;
  logic acc;
  logic clr;
  logic ok;
  assign acc = psel && penable && pready;
  assign clr = acc && (pwrite ? paddr == pwl_pkg::ADDR_MASK
                              : paddr == pwl_pkg::ADDR_FLAG);
  // Pins compared only once a control write has had time to land
  assign ok = settle_q == 2'h3;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= pwl_pkg::CTRL_RST;
      settle_q <= 2'h0;
      clr_q <= 2'h0;
      wake_q <= 0;
    end
    else
    begin
      if (acc && pwrite && paddr == pwl_pkg::ADDR_CTRL)
      begin
        ctrl_q <= pwdata[6:0];
        settle_q <= 2'h0;
      end
      else if (!ok)
        settle_q <= settle_q + 2'h1;
      clr_q <= {clr_q[0], clr};
      wake_q <= wake_out_n_oe ? wake_q + 1 : 0;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("wrong wait count");
  a_err_unmapped: assert property (pready |-> pslverr ==
      (paddr > pwl_pkg::ADDR_BAND || paddr[1:0] != 2'h0))
    else $error("bad error response");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_pin_one:
    assert property (ok |-> io_pin_one_oe == (!ctrl_q[3] && !ctrl_q[0]))
    else $error("pin one drive wrong");
  a_pin_three:
    assert property (ok |-> io_pin_three_oe == (!ctrl_q[5] && !ctrl_q[2]))
    else $error("pin three drive wrong");
  a_out_user:
    assert property (ok && !ctrl_q[3] |-> mem_reset_out_pin_o == ctrl_q[1]
      && mem_reset_out_pin_oe == (ctrl_q[4] || !ctrl_q[1]))
    else $error("output two user drive wrong");
  a_out_latch:
    assert property (ok && ctrl_q[3] |->
      mem_reset_out_pin_oe == (ctrl_q[4] || !mem_reset_out_pin_o))
    else $error("output two type wrong");
  a_wake_len:
    assert property ($fell(wake_out_n_oe) |->
      wake_q == pwl_pkg::WAKE_TICKS * SLOW_DIV)
    else $error("wake pulse length wrong");
  a_irq_release:
    assert property ($fell(irq_out_oe) |-> clr || clr_q != 2'h0)
    else $error("interrupt released without read");
  a_buck_keep:
    assert property (buck_one == pwl_pkg::BUCK_ONE_DEF &&
      buck_two == pwl_pkg::BUCK_TWO_DEF)
    else $error("converter code left default");
endmodule
`default_nettype wire

// File: test/pwl_host.sv
`default_nettype none
// ****
// Host side of the pins
// ****
module pwl_host
(
  input wire logic rst_drive,
  input wire logic conv_drive,
  input wire logic io_pin_one_oe,
  input wire logic io_pin_three_oe,
  input wire logic mem_reset_out_pin_o,
  input wire logic mem_reset_out_pin_oe,
  input wire logic wake_out_n_oe,
  input wire logic irq_out_oe,
  output logic io_pin_one_i,
  output logic io_pin_three_i,
  output logic mem_line,
  output logic wake_line,
  output logic irq_line
);
  // Shared lines are wired-and; released lines sit at the pull-up
  assign io_pin_one_i = rst_drive && !io_pin_one_oe;
  assign io_pin_three_i = conv_drive && !io_pin_three_oe;
  assign mem_line = mem_reset_out_pin_oe ? mem_reset_out_pin_o : 1'b1;
  assign wake_line = !wake_out_n_oe;
  assign irq_line = !irq_out_oe;
endmodule
`default_nettype wire

// File: test/pwl_core_test.sv
`default_nettype none
module pwl_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] D3 = pwl_pkg::BUCK_THREE_DEF;
  localparam logic [5:0] D4 = pwl_pkg::BB_FOUR_DEF;
  localparam logic [5:0] B3_EXP [8] = '{D3, 6'h12, 6'h18, 6'h1f, 6'h3d,
    D3, D3, D3};
  localparam logic [5:0] BB4_EXP [8] = '{D4, D4, D4, D4, 6'h01, 6'h07,
    6'h0d, 6'h14};
  localparam logic [6:0] CTRL_SET [6] = '{7'h00, 7'h07, 7'h10, 7'h12,
    7'h20, 7'h24};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, rerr;
  logic [2:0] sel_band = 3'h0;
  logic power_good = 1'b1, fault_in = 1'b0, push_button_in = 1'b1;
  logic charger_detect_in = 1'b1, rst_drive = 1'b1, conv_drive = 1'b1;
  logic clk_en = 1'b1;
  logic p1_o, p3_o, wk_o, irq_o;
  logic io_pin_one_i, io_pin_one_oe, mem_reset_out_pin_o;
  logic mem_reset_out_pin_oe, io_pin_three_i, io_pin_three_oe;
  logic wake_out_n_oe, irq_out_oe, rails_on, mem_line, wake_line, irq_line;
  logic [5:0] buck_one, buck_two, buck_three, buckboost_four;
  int num_errors = 0, n_compared = 0;
  always #10 pclk = ~pclk;
  pwl_core #(.SHORT_TICKS(40), .LONG_TICKS(80), .POWERUP_TICKS(10),
    .PWRDN_TICKS(5), .SLOW_DIV(4)) dut (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sel_band(sel_band), .power_good(power_good),
    .fault_in(fault_in), .push_button_in(push_button_in),
    .charger_detect_in(charger_detect_in), .io_pin_one_i(io_pin_one_i),
    .io_pin_one_o(p1_o), .io_pin_one_oe(io_pin_one_oe),
    .mem_reset_out_pin_o(mem_reset_out_pin_o),
    .mem_reset_out_pin_oe(mem_reset_out_pin_oe),
    .io_pin_three_i(io_pin_three_i), .io_pin_three_o(p3_o),
    .io_pin_three_oe(io_pin_three_oe), .wake_out_n_o(wk_o),
    .wake_out_n_oe(wake_out_n_oe), .irq_out_o(irq_o),
    .irq_out_oe(irq_out_oe),
    .rails_on(rails_on), .buck_one(buck_one), .buck_two(buck_two),
    .buck_three(buck_three), .buckboost_four(buckboost_four));
  pwl_host host (.rst_drive(rst_drive), .conv_drive(conv_drive),
    .io_pin_one_oe(io_pin_one_oe), .io_pin_three_oe(io_pin_three_oe),
    .mem_reset_out_pin_o(mem_reset_out_pin_o),
    .mem_reset_out_pin_oe(mem_reset_out_pin_oe),
    .wake_out_n_oe(wake_out_n_oe), .irq_out_oe(irq_out_oe),
    .io_pin_one_i(io_pin_one_i), .io_pin_three_i(io_pin_three_i),
    .mem_line(mem_line), .wake_line(wake_line), .irq_line(irq_line));
  // ****
  // Tasks
  // ****
  task automatic finish_test;
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic do_reset(input logic [2:0] band);
    presetn <= 1'b0;
    sel_band <= band;
    tick(12);
    presetn <= 1'b1;
    tick(2);
  endtask
  // Idle cycle after each transfer keeps strobes single-assigned
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n == 20)
      num_errors++;
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    check(32'(s), 32'(v));
  endtask
  // ****
  // Scenarios
  // ****
  initial
  begin
    for (int b = 0; b < 8; b++)
    begin
      do_reset(3'(b));
      check(32'(buck_three), 32'(B3_EXP[b]));
      check(32'(buckboost_four), 32'(BB4_EXP[b]));
    end
    apb(1'b0, pwl_pkg::ADDR_CTRL, 32'h0);
    check(rdata, 32'h3);
    apb(1'b0, pwl_pkg::ADDR_VOLT, 32'h0);
    check(rdata, {8'h0, 6'h14, D3, 12'h3cf});
    apb(1'b0, 8'h18, 32'h0);
    check({rdata[30:0], rerr}, 32'h1);
    push_button_in <= 1'b0;
    tick(30);
    check(32'(rails_on), 32'h0);
    wait_for(rails_on, 1'b1, 100);
    push_button_in <= 1'b1;
    do_reset(3'h7);
    tick(100);
    check(32'(rails_on), 32'h0);
    charger_detect_in <= 1'b0;
    wait_for(rails_on, 1'b1, 100);
    tick(20);
    apb(1'b0, pwl_pkg::ADDR_FLAG, 32'h0);
    push_button_in <= 1'b0;
    wait_for(wake_line, 1'b0, 40);
    wait_for(irq_line, 1'b0, 20);
    apb(1'b0, pwl_pkg::ADDR_STAT, 32'h0);
    check(rdata & 32'h7, 32'h4);
    apb(1'b0, pwl_pkg::ADDR_FLAG, 32'h0);
    check(rdata, 32'h1);
    tick(2);
    check(32'(irq_line), 32'h1);
    push_button_in <= 1'b1;
    tick(30);
    apb(1'b0, pwl_pkg::ADDR_FLAG, 32'h0);
    check(rdata, 32'h1);
    apb(1'b0, pwl_pkg::ADDR_FLAG, 32'h0);
    check(rdata, 32'h0);
    apb(1'b1, pwl_pkg::ADDR_MASK, 32'h1);
    push_button_in <= 1'b0;
    tick(30);
    check(32'(irq_line), 32'h1);
    apb(1'b0, pwl_pkg::ADDR_FLAG, 32'h0);
    check(rdata, 32'h1);
    push_button_in <= 1'b1;
    charger_detect_in <= 1'b1;
    tick(30);
    check(32'(irq_line), 32'h0);
    apb(1'b0, pwl_pkg::ADDR_STAT, 32'h0);
    check(rdata & 32'h7, 32'h7);
    apb(1'b0, pwl_pkg::ADDR_FLAG, 32'h0);
    check(rdata, 32'h3);
    apb(1'b1, pwl_pkg::ADDR_MASK, 32'h0);
    fault_in <= 1'b1;
    wait_for(irq_line, 1'b0, 1600);
    apb(1'b0, pwl_pkg::ADDR_FLAG, 32'h0);
    check(rdata, 32'h4);
    check({28'h0, p1_o, p3_o, wk_o, irq_o}, 32'h0);
    wait_for(irq_line, 1'b0, 1600);
    fault_in <= 1'b0;
    foreach (CTRL_SET[i])
    begin
      apb(1'b1, pwl_pkg::ADDR_CTRL, 32'(CTRL_SET[i]));
      conv_drive <= 1'b0;
      tick(10);
      conv_drive <= 1'b1;
      tick(10);
      check(32'(mem_line), 32'(CTRL_SET[i][1]));
      check(32'(io_pin_one_oe), 32'(!CTRL_SET[i][0]));
      check(32'(io_pin_three_oe),
            32'(!CTRL_SET[i][5] && !CTRL_SET[i][2]));
    end
    apb(1'b1, pwl_pkg::ADDR_CTRL, 32'h8);
    rst_drive <= 1'b0;
    tick(10);
    check(32'(mem_line), 32'h0);
    rst_drive <= 1'b1;
    tick(10);
    check(32'(mem_line), 32'h1);
    power_good <= 1'b0;
    tick(10);
    rst_drive <= 1'b0;
    tick(10);
    check(32'(mem_line), 32'h1);
    apb(1'b1, pwl_pkg::ADDR_CTRL, 32'h18);
    tick(4);
    check(32'(mem_reset_out_pin_oe), 32'h1);
    power_good <= 1'b1;
    rst_drive <= 1'b1;
    apb(1'b1, pwl_pkg::ADDR_CTRL, 32'h43);
    push_button_in <= 1'b0;
    tick(250);
    check(32'(rails_on), 32'h1);
    wait_for(rails_on, 1'b0, 200);
    wait_for(rails_on, 1'b1, 100);
    wait_for(rails_on, 1'b0, 400);
    wait_for(rails_on, 1'b1, 100);
    // Frozen clock enable must hold off the next long-press restart
    clk_en <= 1'b0;
    tick(400);
    check(32'(rails_on), 32'h1);
    clk_en <= 1'b1;
    wait_for(rails_on, 1'b0, 400);
    finish_test;
  end
  initial
  begin
    tick(20000);
    num_errors++;
    finish_test;
  end
endmodule
bind pwl_core pwl_core_sva #(.SLOW_DIV(SLOW_DIV)) u_sva (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .io_pin_one_oe(io_pin_one_oe),
  .mem_reset_out_pin_o(mem_reset_out_pin_o),
  .mem_reset_out_pin_oe(mem_reset_out_pin_oe),
  .io_pin_three_oe(io_pin_three_oe), .wake_out_n_oe(wake_out_n_oe),
  .irq_out_oe(irq_out_oe), .buck_one(buck_one), .buck_two(buck_two));
`default_nettype wire
